// file: core/ccm_consts.svh
// Register map, field positions, reset values and mode codes of the
// capture/compare mode control block. Definitions only.
`ifndef CCM_CONSTS_SVH
`define CCM_CONSTS_SVH

// Register offsets on the plain register port
`define CCM_A_T3_LO     4'h0
`define CCM_A_T3_HI     4'h1
`define CCM_A_T3_CTL    4'h2
`define CCM_A_UC1       4'h3
`define CCM_A_UDL1      4'h4
`define CCM_A_UDH1      4'h5
`define CCM_A_UC2       4'h6
`define CCM_A_UDL2      4'h7
`define CCM_A_UDH2      4'h8
`define CCM_A_STAT      4'h9
`define CCM_A_CFG       4'hA
`define CCM_A_LAST      4'hA

// Timer3 control fields
`define CCM_T3C_ON      0
`define CCM_T3C_EXT     1
`define CCM_T3C_SEL1    3
`define CCM_T3C_PS      5:4
`define CCM_T3C_SEL2    6
`define CCM_T3C_RD16    7
`define CCM_T3C_RESET   8'h00

// Unit control fields
`define CCM_UC_MODE     3:0
`define CCM_UC_DUTY     5:4
`define CCM_UC_RESET    6'h00

// Status and configuration fields
`define CCM_ST_OVF      0
`define CCM_ST_IRQEN    1
`define CCM_ST_UIF      2
`define CCM_CFG_OD1     0
`define CCM_CFG_OD2     1
`define CCM_CFG_PINSEL  2
`define CCM_CFG_OSCEN   3
`define CCM_CFG_RESET   4'h4

// Unit mode codes
`define CCM_M_OFF       4'h0
`define CCM_M_CMP_TOG   4'h2
`define CCM_M_CAP_FALL  4'h4
`define CCM_M_CAP_RISE  4'h5
`define CCM_M_CAP_R4    4'h6
`define CCM_M_CMP_SET   4'h8
`define CCM_M_CMP_CLR   4'h9
`define CCM_M_CMP_SWI   4'hA
`define CCM_M_CMP_SEV   4'hB

`endif

// file: core/ccm_pkg.sv
// Types shared by the capture/compare mode control block.
// Assumes ccm_consts.svh is on the include path.
package ccm_pkg;
    typedef enum logic [1:0] {
        CCM_KIND_OFF = 2'b00,
        CCM_KIND_CAP = 2'b01,
        CCM_KIND_CMP = 2'b10,
        CCM_KIND_PWM = 2'b11
    } ccm_kind_t;

    // Reserved codes 1 and 3 behave as a disabled unit; 7 decodes as capture
    function automatic ccm_kind_t ccm_kind_of(input logic [3:0] m);
        ccm_kind_t k;
        k = CCM_KIND_OFF;
        if (m[3:2] == 2'b11)
            k = CCM_KIND_PWM;
        else if (m[3:2] == 2'b01)
            k = CCM_KIND_CAP;
        else if (m[3] || m == 4'h2)
            k = CCM_KIND_CMP;
        return k;
    endfunction
endpackage

// file: core/ccm_t3_if.sv
// Control and status bundle between the register block and timer3.
// Assumes both ends share one clock.
`timescale 1ns/1ps
interface ccm_t3_if;
    logic        on;
    logic        ext_sel;
    logic [1:0]  prescale;
    logic        ext_rise;
    logic        wr_lo;
    logic        wr_hi;
    logic [15:0] wdata;
    logic        sev_reset;
    logic [15:0] count;
    logic        wrap;
    modport ctl (output on, ext_sel, prescale, ext_rise, wr_lo, wr_hi, wdata, sev_reset,
                 input count, wrap);
    modport tmr (input on, ext_sel, prescale, ext_rise, wr_lo, wr_hi, wdata, sev_reset,
                 output count, wrap);
endinterface

// file: core/ccm_timer3.sv
// 16-bit timer3 counter with 1/2/4/8 prescale and trigger reset.
// Assumes ext_rise is a one-cycle pulse already synchronous to clk.
`timescale 1ns/1ps
module ccm_timer3
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Control and count
    ccm_t3_if.tmr    t3
);
    logic [15:0] count;
    logic [2:0]  pre;
    logic [15:0] next_count;
    logic [2:0]  next_pre;

    wire       src_tick = t3.ext_sel ? t3.ext_rise : 1'b1;
    wire [2:0] pre_max  = {&t3.prescale, t3.prescale[1], |t3.prescale};
    wire       step     = t3.on & src_tick & (pre == pre_max);
    wire       sw_wr    = t3.wr_lo | t3.wr_hi;

    // A write or a trigger reset is never counted as an overflow
    assign t3.wrap  = step & (count == 16'hFFFF) & ~sw_wr & ~t3.sev_reset;
    assign t3.count = count;

    always_comb
    begin
        next_count = count;
        if (sw_wr)
            next_count = {t3.wr_hi ? t3.wdata[15:8] : count[15:8],
                          t3.wr_lo ? t3.wdata[7:0] : count[7:0]};
        else if (t3.sev_reset)
            next_count = 16'h0000;
        else if (step)
            next_count = count + 16'h0001;
        next_pre = pre;
        if (t3.wr_lo || t3.sev_reset || step)
            next_pre = 3'h0;
        else if (t3.on && src_tick)
            next_pre = pre + 3'h1;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            count <= 16'h0000;
            pre   <= 3'h0;
        end
        else
        begin
            count <= next_count;
            pre   <= next_pre;
        end
    end
endmodule

// file: core/ccm_pin_drive.sv
// Pin multiplexer: unit outputs onto three pins, with open-drain option.
// Assumes the port logic supplies direction and data latch per pin.
`timescale 1ns/1ps
module ccm_pin_drive
(
    // Unit side
    input  wire logic [1:0] u_drive,
    input  wire logic [1:0] u_out,
    input  wire logic [1:0] u_od,
    input  wire logic       pin_sel,
    output wire logic [1:0] u_in,
    // Port side: 0 first unit, 1 default second, 2 alternate second
    input  wire logic [2:0] dir_out,
    input  wire logic [2:0] port_latch,
    input  wire logic [2:0] pin_in,
    output wire logic [2:0] pin_out,
    output wire logic [2:0] pin_oe
);
    wire [2:0] owner = {~pin_sel, pin_sel, 1'b0};
    wire [1:0] unit2_in_sel = {1'b0, pin_sel};

    assign u_in = {unit2_in_sel[0] ? pin_in[1] : pin_in[2], pin_in[0]};

    for (genvar p = 0; p < 3; p++)
    begin : g_pin
        wire mine = (p == 0) ? 1'b1 : owner[p];
        wire drv  = mine & u_drive[owner[p]];
        wire od   = u_od[owner[p]];
        // Direction comes from the port; the unit picks the level, and in open-drain also releases the pin
        assign pin_out[p] = drv ? (od ? 1'b0 : u_out[owner[p]]) : port_latch[p];
        assign pin_oe[p]  = dir_out[p] & (drv & od ? ~u_out[owner[p]] : 1'b1);
    end
endmodule

// file: core/ccm_top.sv
// Mode control for two capture/compare/PWM units and the timer3 counter.
// Assumes all inputs are synchronous to sys_clk; timer1, timer2 and the
// A/D converter live outside and are seen through plain ports.
//
// The register offsets and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
`include "ccm_consts.svh"
module ccm_top
    import ccm_pkg::*;
#(
    parameter int DUTY_W = 10
)
(
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        nrst,
    // Register port
    input  wire logic [3:0]  addr,
    input  wire logic [7:0]  wr_data,
    input  wire logic        wr_en,
    input  wire logic        rd_en,
    output logic      [7:0]  rd_data,
    // Timers and converter outside
    input  wire logic [15:0] t1_count,
    input  wire logic        t3_ext_rise,
    input  wire logic [9:0]  t2_count10,
    input  wire logic        t2_period,
    input  wire logic        adc_enabled,
    output wire logic        adc_start,
    output wire logic        t1_reset,
    output wire logic        t1_osc_enable,
    // Interrupt requests
    output wire logic        t3_irq_req,
    output wire logic [1:0]  unit_irq_flag,
    // Pins
    input  wire logic [2:0]  pin_in,
    input  wire logic [2:0]  pin_dir_out,
    input  wire logic [2:0]  port_latch,
    output wire logic [2:0]  pin_out,
    output wire logic [2:0]  pin_oe
);
    if (DUTY_W != 10)
    begin : g_bad_width
        $error("ccm_top: duty width must be 10");
    end

    // Reset release through two flops
    logic rst_meta;
    logic rst_n;

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end
        else
        begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // Register decode
    wire wr_t3_lo  = wr_en & (addr == `CCM_A_T3_LO);
    wire wr_t3_hi  = wr_en & (addr == `CCM_A_T3_HI);
    wire wr_t3_ctl = wr_en & (addr == `CCM_A_T3_CTL);
    wire wr_stat   = wr_en & (addr == `CCM_A_STAT);
    wire wr_cfg    = wr_en & (addr == `CCM_A_CFG);
    wire rd_t3_lo  = rd_en & (addr == `CCM_A_T3_LO);

    logic [7:0] t3_ctl;
    logic [7:0] t3_hi_buf;
    logic [3:0] cfg;
    logic       ovf_flag;
    logic       irq_en;
    logic [7:0] next_rd_data;

    wire rd16    = t3_ctl[`CCM_T3C_RD16];
    wire sel2    = t3_ctl[`CCM_T3C_SEL2];
    wire sel1    = t3_ctl[`CCM_T3C_SEL1];
    wire [1:0] use_t3 = {sel2 | sel1, sel2};

    // Timer3
    ccm_t3_if t3b ();

    assign t3b.on       = t3_ctl[`CCM_T3C_ON];
    assign t3b.ext_sel  = t3_ctl[`CCM_T3C_EXT];
    assign t3b.prescale = t3_ctl[`CCM_T3C_PS];
    assign t3b.ext_rise = t3_ext_rise;
    // Buffered mode: low-byte write carries the buffered high byte along
    assign t3b.wr_lo    = wr_t3_lo;
    assign t3b.wr_hi    = rd16 ? wr_t3_lo : wr_t3_hi;
    assign t3b.wdata    = rd16 ? {t3_hi_buf, wr_data} : {wr_data, wr_data};

    ccm_timer3 u_timer3
    (
        .clk   (sys_clk),
        .rst_n (rst_n),
        .t3    (t3b.tmr)
    );

    // Per-unit results gathered for sharing
    wire [1:0] u_drive;
    wire [1:0] u_out;
    wire [1:0] u_sev;
    wire [1:0] u_in;
    wire [1:0] u_flag;
    wire [7:0] reg_view [0:10];

    assign t3b.sev_reset = |(u_sev & use_t3);
    assign t1_reset      = |(u_sev & ~use_t3);
    // First unit trigger never reaches the converter
    assign adc_start     = u_sev[1] & adc_enabled;
    assign unit_irq_flag = u_flag;

    for (genvar i = 0; i < 2; i++)
    begin : g_unit
        localparam logic [3:0] A_CTL = (i == 0) ? `CCM_A_UC1 : `CCM_A_UC2;
        localparam logic [3:0] A_DL  = (i == 0) ? `CCM_A_UDL1 : `CCM_A_UDL2;
        localparam logic [3:0] A_DH  = (i == 0) ? `CCM_A_UDH1 : `CCM_A_UDH2;

        logic [5:0]  ctrl;
        logic [15:0] data;
        logic [1:0]  duty_lat;
        logic        flag;
        logic        out_lat;
        logic        pin_d;
        logic        match_d;
        logic [3:0]  pre;
        logic        next_out;
        logic [15:0] next_data;
        logic [3:0]  next_pre;
        ccm_kind_t   kind;

        wire [3:0]  mode   = ctrl[`CCM_UC_MODE];
        wire [3:0]  wmode  = wr_data[`CCM_UC_MODE];
        wire        wr_ctl = wr_en & (addr == A_CTL);
        wire        wr_dl  = wr_en & (addr == A_DL);
        wire        wr_dh  = wr_en & (addr == A_DH);
        wire [15:0] base   = use_t3[i] ? t3b.count : t1_count;

        assign kind = ccm_kind_of(mode);

        // Capture edges and event prescale
        wire rise     = u_in[i] & ~pin_d;
        wire fall     = ~u_in[i] & pin_d;
        wire is_cap   = (kind == CCM_KIND_CAP);
        wire pre_full = (mode == `CCM_M_CAP_R4) ? (pre == 4'h3) : (pre == 4'hF);
        wire cap_ev   = is_cap & (((mode == `CCM_M_CAP_FALL) & fall)
                                | ((mode == `CCM_M_CAP_RISE) & rise)
                                | (mode[1] & rise & pre_full));

        // Compare acts once per arrival at the match value
        wire match    = (kind == CCM_KIND_CMP) & (base == data);
        wire hit      = match & ~match_d;
        wire is_pwm   = (kind == CCM_KIND_PWM);
        wire [9:0] duty_now = {data[15:8], duty_lat};
        wire pwm_end  = is_pwm & (t2_count10 == duty_now);

        assign u_sev[i]   = hit & (mode == `CCM_M_CMP_SEV);
        assign u_drive[i] = is_pwm | ((kind == CCM_KIND_CMP)
                                      & (mode != `CCM_M_CMP_SWI));
        assign u_out[i]   = out_lat;
        assign u_flag[i]  = flag;

        assign reg_view[A_CTL] = {2'b00, ctrl};
        assign reg_view[A_DL]  = data[7:0];
        assign reg_view[A_DH]  = data[15:8];

        always_comb
        begin
            next_out = out_lat;
            if (wr_ctl)
            begin
                if (wmode == `CCM_M_OFF)
                    next_out = 1'b0;
                else if (wmode == `CCM_M_CMP_SET)
                    next_out = 1'b0;
                else if (wmode == `CCM_M_CMP_CLR)
                    next_out = 1'b1;
            end
            else if (kind == CCM_KIND_OFF)
                next_out = 1'b0;
            else if (is_pwm)
            begin
                if (t2_period)
                    next_out = 1'b1;
                else if (pwm_end)
                    next_out = 1'b0;
            end
            else if (hit)
            begin
                case (mode)
                    `CCM_M_CMP_TOG: next_out = ~out_lat;
                    `CCM_M_CMP_SET: next_out = 1'b1;
                    `CCM_M_CMP_CLR: next_out = 1'b0;
                    default:        next_out = out_lat;
                endcase
            end
        end

        always_comb
        begin
            next_data = data;
            if (wr_dl)
                next_data[7:0] = wr_data;
            if (wr_dh)
                next_data[15:8] = wr_data;
            // Duty low byte moves to the high half at each period start
            if (is_pwm && t2_period)
                next_data[15:8] = data[7:0];
            // A newer capture overwrites whatever is still unread
            if (cap_ev)
                next_data = base;
        end

        always_comb
        begin
            next_pre = pre;
            if (!is_cap)
                next_pre = 4'h0;
            else if (mode[1] && rise)
                next_pre = pre_full ? 4'h0 : pre + 4'h1;
        end

        always_ff @(posedge sys_clk or negedge rst_n)
        begin
            if (!rst_n)
            begin
                ctrl     <= `CCM_UC_RESET;
                data     <= 16'h0000;
                duty_lat <= 2'h0;
                out_lat  <= 1'b0;
                pin_d    <= 1'b0;
                match_d  <= 1'b0;
                pre      <= 4'h0;
            end
            else
            begin
                if (wr_ctl)
                    ctrl <= wr_data[5:0];
                if (is_pwm && t2_period)
                    duty_lat <= ctrl[`CCM_UC_DUTY];
                data    <= next_data;
                out_lat <= next_out;
                pin_d   <= u_in[i];
                match_d <= match;
                pre     <= next_pre;
            end
        end

        // Hardware set wins over a software clear in the same cycle
        always_ff @(posedge sys_clk or negedge rst_n)
        begin
            if (!rst_n)
                flag <= 1'b0;
            else if (cap_ev || (hit && mode != `CCM_M_OFF))
                flag <= 1'b1;
            else if (wr_stat)
                flag <= wr_data[`CCM_ST_UIF + i];
        end
    end

    // Pin routing and drivers
    ccm_pin_drive u_pins
    (
        .u_drive    (u_drive),
        .u_out      (u_out),
        .u_od       (cfg[`CCM_CFG_OD2:`CCM_CFG_OD1]),
        .pin_sel    (cfg[`CCM_CFG_PINSEL]),
        .u_in       (u_in),
        .dir_out    (pin_dir_out),
        .port_latch (port_latch),
        .pin_in     (pin_in),
        .pin_out    (pin_out),
        .pin_oe     (pin_oe)
    );

    // Timer3 control, buffer, configuration
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            t3_ctl    <= `CCM_T3C_RESET;
            t3_hi_buf <= 8'h00;
            cfg       <= `CCM_CFG_RESET;
            irq_en    <= 1'b0;
        end
        else
        begin
            if (wr_t3_ctl)
                t3_ctl <= wr_data;
            if (wr_cfg)
                cfg <= wr_data[3:0];
            if (wr_stat)
                irq_en <= wr_data[`CCM_ST_IRQEN];
            // Low-byte read freezes the high byte for a coherent pair
            if (rd16 && rd_t3_lo)
                t3_hi_buf <= t3b.count[15:8];
            else if (rd16 && wr_t3_hi)
                t3_hi_buf <= wr_data;
        end
    end

    // Overflow flag: set wins, cleared only by writing zero
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            ovf_flag <= 1'b0;
        else if (t3b.wrap)
            ovf_flag <= 1'b1;
        else if (wr_stat)
            ovf_flag <= wr_data[`CCM_ST_OVF];
    end

    assign t3_irq_req    = ovf_flag & irq_en;
    assign t1_osc_enable = cfg[`CCM_CFG_OSCEN];

    // Read view of the remaining registers
    assign reg_view[`CCM_A_T3_LO]  = t3b.count[7:0];
    assign reg_view[`CCM_A_T3_HI]  = rd16 ? t3_hi_buf : t3b.count[15:8];
    assign reg_view[`CCM_A_T3_CTL] = t3_ctl;
    assign reg_view[`CCM_A_STAT]   = {4'h0, u_flag, irq_en, ovf_flag};
    assign reg_view[`CCM_A_CFG]    = {4'h0, cfg};

    // Read data stand for one cycle only; unmapped reads give zero
    assign next_rd_data = (rd_en && addr <= `CCM_A_LAST) ? reg_view[addr] : 8'h00;

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            rd_data <= 8'h00;
        else
            rd_data <= next_rd_data;
    end
endmodule

// file: verif/ccm_top_assertions.sv
// Port-level checks of ccm_top, bound into every instance.
// Assumes the register map of ccm_consts.svh and inputs synchronous to sys_clk.
`timescale 1ns/1ps
`include "ccm_consts.svh"
module ccm_top_assertions
(
    // Clock and reset
    input wire logic       sys_clk,
    input wire logic       nrst,
    // Register port
    input wire logic [3:0] addr,
    input wire logic       wr_en,
    input wire logic       rd_en,
    input wire logic [7:0] rd_data,
    // Converter, timers and requests
    input wire logic       adc_enabled,
    input wire logic       adc_start,
    input wire logic       t1_osc_enable,
    input wire logic       t3_irq_req,
    input wire logic [1:0] unit_irq_flag,
    // Pins
    input wire logic [2:0] pin_dir_out,
    input wire logic [2:0] pin_oe
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    rd_idle_a: assert property (!$past(rd_en) |-> rd_data == 8'h00)
        else $error("read data outside its answer cycle");
    rd_unmapped_a: assert property (rd_en && addr > `CCM_A_LAST |=> rd_data == 8'h00)
        else $error("unmapped read returned data");
    adc_gate_a: assert property (adc_start |-> adc_enabled)
        else $error("conversion start while converter disabled");
    adc_once_a: assert property (adc_start |=> !adc_start)
        else $error("trigger pulse longer than one cycle");
    oe_dir_a: assert property ((pin_oe & ~pin_dir_out) == 3'h0)
        else $error("pin driven against its direction");
    uflag_hold_a: assert property ($fell(unit_irq_flag[0]) || $fell(unit_irq_flag[1])
        |-> $past(wr_en) && $past(addr) == `CCM_A_STAT)
        else $error("unit flag cleared without software write");
    ovf_hold_a: assert property ($fell(t3_irq_req)
        |-> $past(wr_en) && $past(addr) == `CCM_A_STAT)
        else $error("timer3 request dropped without software write");
    osc_write_a: assert property ($changed(t1_osc_enable)
        |-> $past(wr_en) && $past(addr) == `CCM_A_CFG)
        else $error("oscillator enable moved without write");
endmodule

bind ccm_top ccm_top_assertions chk (.sys_clk(sys_clk), .nrst(nrst), .addr(addr),
    .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .adc_enabled(adc_enabled),
    .adc_start(adc_start), .t1_osc_enable(t1_osc_enable), .t3_irq_req(t3_irq_req),
    .unit_irq_flag(unit_irq_flag), .pin_dir_out(pin_dir_out), .pin_oe(pin_oe));

// file: verif/ccm_pin_model.sv
// Far side of the three unit pins: an external source per pin and pull-ups.
// Assumes pin_oe high means the block drives the pin.
`timescale 1ns/1ps
module ccm_pin_model
(
    // Block side
    input  wire logic [2:0] pin_out,
    input  wire logic [2:0] pin_oe,
    // Bench commands
    input  wire logic [2:0] ext_drive,
    input  wire logic [2:0] ext_level,
    // Wire levels
    output wire logic [2:0] pin_in
);
    // Undriven lines float up, so a released open-drain output reads high
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_drive & ext_level)
                  | (~pin_oe & ~ext_drive);
endmodule

// file: verif/ccm_top_tb_top.sv
// Self-checking bench for ccm_top: register tasks and scenario sequences.
// Assumes ccm_pin_model at the pins and the bound port checker.
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin errors++; $display("BAD %0t %h %h", $time, g, e); end end
module ccm_top_tb_top;
    logic        sys_clk, nrst, wr_en, rd_en, t3_ext_rise, t2_period, adc_enabled;
    logic [3:0]  addr;
    logic [7:0]  wr_data;
    logic [15:0] t1_count;
    logic [9:0]  t2_count10;
    logic [2:0]  pin_dir_out, port_latch, ext_drive, ext_level;
    logic [15:0] modes = 16'hA298;
    logic [3:0]  ent = 4'h2;
    logic [3:0]  mat = 4'h5;
    wire  [7:0]  rd_data;
    wire  [2:0]  pin_in, pin_out, pin_oe;
    wire  [1:0]  unit_irq_flag;
    wire         adc_start, t1_reset, t1_osc_enable, t3_irq_req;
    int          errors, checks_done, i, k;

    ccm_top uut (.sys_clk(sys_clk), .nrst(nrst), .addr(addr), .wr_data(wr_data),
        .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .t1_count(t1_count),
        .t3_ext_rise(t3_ext_rise), .t2_count10(t2_count10), .t2_period(t2_period),
        .adc_enabled(adc_enabled), .adc_start(adc_start), .t1_reset(t1_reset),
        .t1_osc_enable(t1_osc_enable), .t3_irq_req(t3_irq_req),
        .unit_irq_flag(unit_irq_flag), .pin_in(pin_in), .pin_dir_out(pin_dir_out),
        .port_latch(port_latch), .pin_out(pin_out), .pin_oe(pin_oe));
    ccm_pin_model pins (.pin_out(pin_out), .pin_oe(pin_oe), .ext_drive(ext_drive),
        .ext_level(ext_level), .pin_in(pin_in));

    initial
    begin
        sys_clk = 1'h0;
        forever #25 sys_clk = ~sys_clk;
    end

    task final_report;
        if (errors == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    task wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        addr <= a;
        wr_data <= d;
        wr_en <= 1'h1;
        @(posedge sys_clk);
        wr_en <= 1'h0;
    endtask

    task rdc(input logic [3:0] a, input logic [7:0] e);
        @(posedge sys_clk);
        addr <= a;
        rd_en <= 1'h1;
        @(posedge sys_clk);
        rd_en <= 1'h0;
        @(negedge sys_clk);
        `CHK(rd_data, e)
    endtask

    // Each pulse is wide enough for the design's one-sample edge detector
    task pulses(input int n);
        repeat (n)
        begin
            @(posedge sys_clk) ext_level[0] <= 1'h1;
            cyc(2);
            ext_level[0] <= 1'h0;
            cyc(2);
        end
    endtask

    task period(input logic [9:0] c);
        @(posedge sys_clk) t2_period <= 1'h1;
        t2_count10 <= c;
        @(posedge sys_clk) t2_period <= 1'h0;
        cyc(2);
        @(negedge sys_clk);
    endtask

    // Hang guard: a bench that never ends is a failure
    initial
    begin
        cyc(20000);
        errors++;
        final_report;
    end

    initial
    begin
        {nrst, wr_en, rd_en, t3_ext_rise, t2_period, adc_enabled} = 6'h00;
        {addr, wr_data, t1_count, t2_count10} = 38'h0;
        {port_latch, ext_drive, ext_level} = 9'h000;
        pin_dir_out = 3'h7;
        cyc(10);
        nrst <= 1'h1;
        cyc(3);
        for (i = 0; i < 16; i++)
            rdc(4'(i), i == 10 ? 8'h04 : 8'h00);
        `CHK({unit_irq_flag, t3_irq_req}, 3'h0)
        for (i = 3; i < 9; i++)
        begin
            wr(4'(i), 8'hF5);
            rdc(4'(i), (i == 3 || i == 6) ? 8'h35 : 8'hF5);
        end
        wr(4'h3, 8'h00);
        wr(4'h6, 8'h00);
        // Timer3 from FFF0 wraps after sixteen cycles
        wr(4'h1, 8'hFF);
        wr(4'h0, 8'hF0);
        wr(4'h9, 8'h02);
        wr(4'h2, 8'h01);
        cyc(30);
        rdc(4'h9, 8'h03);
        `CHK(t3_irq_req, 1'h1)
        cyc(40);
        rdc(4'h9, 8'h03);
        wr(4'h9, 8'h01);
        @(negedge sys_clk);
        `CHK(t3_irq_req, 1'h0)
        wr(4'h9, 8'h00);
        // Second unit trigger on timer3 at count 0010
        wr(4'h2, 8'h00);
        wr(4'h7, 8'h10);
        wr(4'h8, 8'h00);
        wr(4'h1, 8'h00);
        wr(4'h0, 8'h00);
        adc_enabled <= 1'h1;
        wr(4'h6, 8'h0B);
        wr(4'h2, 8'h08);
        wr(4'h2, 8'h09);
        k = 0;
        while (adc_start !== 1'h1 && k < 200)
        begin
            @(negedge sys_clk);
            k++;
        end
        if (k >= 200)
        begin
            errors++;
            final_report;
        end
        `CHK({adc_start, t1_reset}, 2'h2)
        rdc(4'h0, 8'h00);
        rdc(4'h9, 8'h08);
        adc_enabled <= 1'h0;
        cyc(40);
        wr(4'h6, 8'h00);
        wr(4'h9, 8'h00);
        // First unit compares on timer1 against 1234
        wr(4'h4, 8'h34);
        wr(4'h5, 8'h12);
        for (i = 0; i < 4; i++)
        begin
            wr(4'h3, {4'h0, modes[4*i+:4]});
            @(negedge sys_clk);
            `CHK(pin_out[0], ent[i])
            @(posedge sys_clk) t1_count <= 16'h1234;
            cyc(3);
            @(negedge sys_clk);
            `CHK(pin_out[0], mat[i])
            `CHK(unit_irq_flag[0], 1'h1)
            @(posedge sys_clk) t1_count <= 16'h0000;
            wr(4'h9, 8'h00);
        end
        wr(4'hA, 8'h05);
        wr(4'h3, 8'h08);
        @(negedge sys_clk);
        `CHK({pin_oe[0], pin_out[0]}, 2'h2)
        @(posedge sys_clk) t1_count <= 16'h1234;
        cyc(3);
        @(negedge sys_clk);
        `CHK({pin_oe[0], pin_in[0]}, 2'h1)
        wr(4'hA, 8'h04);
        // First unit trigger on timer1: resets timer1, never the converter
        @(posedge sys_clk) t1_count <= 16'h0000;
        wr(4'h3, 8'h0B);
        @(posedge sys_clk) t1_count <= 16'h1234;
        adc_enabled <= 1'h1;
        @(negedge sys_clk);
        `CHK({t1_reset, adc_start}, 2'h2)
        wr(4'h3, 8'h00);
        adc_enabled <= 1'h0;
        wr(4'h9, 8'h00);
        // Capture on the first unit pin, driven from outside
        pin_dir_out <= 3'h6;
        ext_drive <= 3'h1;
        t1_count <= 16'h4321;
        wr(4'h3, 8'h05);
        pulses(1);
        rdc(4'h4, 8'h21);
        rdc(4'h5, 8'h43);
        rdc(4'h9, 8'h04);
        wr(4'h3, 8'h04);
        t1_count <= 16'h1111;
        pulses(1);
        rdc(4'h4, 8'h11);
        // Select 1x hands timer3 to the first unit as well
        wr(4'h2, 8'h40);
        wr(4'h1, 8'h66);
        wr(4'h0, 8'h77);
        pulses(1);
        rdc(4'h5, 8'h66);
        for (i = 0; i < 2; i++)
        begin
            wr(4'h3, 8'h00);
            wr(4'h3, 8'h06 + 8'(i));
            wr(4'h9, 8'h00);
            pulses(i == 0 ? 3 : 15);
            rdc(4'h9, 8'h00);
            pulses(1);
            rdc(4'h9, 8'h04);
        end
        wr(4'h3, 8'h00);
        pin_dir_out <= 3'h7;
        ext_drive <= 3'h0;
        // PWM on the second unit: duty {02, 01} is 009
        wr(4'h7, 8'h02);
        wr(4'h6, 8'h1C);
        period(10'h008);
        `CHK(pin_out[1], 1'h1)
        @(posedge sys_clk) t2_count10 <= 10'h009;
        cyc(2);
        @(negedge sys_clk);
        `CHK(pin_out[1], 1'h0)
        wr(4'hA, 8'h08);
        @(negedge sys_clk);
        `CHK(t1_osc_enable, 1'h1)
        period(10'h001);
        `CHK(pin_out[2:1], 2'h2)
        `CHK(pin_oe[2], 1'h1)
        final_report;
    end
endmodule
